// file: hw/gio_cfg.svh
// Constants for the parallel port block: addresses, reset values and field positions.
`ifndef GIO_CFG_SVH
`define GIO_CFG_SVH

// Number of port slots and the width of one slot on the pin vectors.
`define GIO_NPORT 8
`define GIO_SLOT_W 8
// Port data latches, one per port, at consecutive addresses.
`define GIO_DATA_FIRST 12'h001
`define GIO_DATA_LAST 12'h008
// Port direction registers, one per port, at consecutive addresses.
`define GIO_DIR_FIRST 12'h010
`define GIO_DIR_LAST 12'h017
// Pin-read registers of the three-bit and five-bit ports.
`define GIO_P2_PIN_READ 12'hf9c
`define GIO_P3_PIN_READ 12'hf9d
// Segment-select registers.
`define GIO_P1_SEG 12'hf9e
`define GIO_P5_SEG 12'hf9f
`define GIO_P7_SEG 12'hfa0
`define GIO_P8_SEG 12'hfa1
// Port slots that own a segment-select register (slots 0, 4, 6 and 7).
`define GIO_SEG_PORTS 8'hd1
// Slot numbers of the ports with a pin-read register.
`define GIO_P2_SLOT 1
`define GIO_P3_SLOT 2
// Reset values of the output latches and control registers.
`define GIO_LATCH_RST 8'h00
`define GIO_P2_LATCH_RST 8'h07
`define GIO_CTRL_RST 8'h00
// Host registers on the APB side.
`define GIO_APB_CMD 12'h000
`define GIO_APB_STAT 12'h004
`define GIO_CMD_WDATA_LSB 12
`define GIO_CMD_WE_BIT 20
`define GIO_STAT_BUSY_BIT 0
`define GIO_STAT_ERR_BIT 1
`define GIO_STAT_RDATA_LSB 8

`endif

// file: hw/gio_pkg.sv
// Types and the shared address check of the parallel port block.
`default_nettype none
`include "gio_cfg.svh"
package gio_pkg;

  // Bus cycle states of the port end.
  typedef enum logic [2:0] {
    GIO_IDLE = 3'h1,
    GIO_S1 = 3'h2,
    GIO_S2 = 3'h4
  } gio_dev_st_t;

  // States of the controller end.
  typedef enum logic [1:0] {
    GIO_H_IDLE = 2'h1,
    GIO_H_BUSY = 2'h2
  } gio_host_st_t;

  // State of the port end.
  typedef struct packed {
    gio_dev_st_t st;
    logic [7:0] rdata;
    logic err;
  } gio_dev_state_t;

  // State of one port cell.
  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] seg;
  } gio_cell_state_t;

  // State of the controller end.
  typedef struct packed {
    gio_host_st_t st;
    logic [11:0] addr;
    logic we;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic err;
    logic [31:0] prdata;
    logic pslverr;
  } gio_host_state_t;

  // True when the address exists and allows the given direction.
  function automatic logic gio_acc_ok(input logic [11:0] a, input logic we);
    logic ok;
    ok = 1'b0;
    if (a >= `GIO_DATA_FIRST && a <= `GIO_DATA_LAST) begin
      ok = 1'b1;
    end else if (a >= `GIO_DIR_FIRST && a <= `GIO_DIR_LAST) begin
      ok = 1'b1;
    end else if (a >= `GIO_P1_SEG && a <= `GIO_P8_SEG) begin
      ok = 1'b1;
    end else if (a == `GIO_P2_PIN_READ || a == `GIO_P3_PIN_READ) begin
      ok = !we;
    end
    return ok;
  endfunction

endpackage
`default_nettype wire

// file: hw/gio_bus_if.sv
// Instruction bus between the controller end and the port end.
`default_nettype none
interface gio_bus_if;
  // Request held by the controller until acknowledged.
  logic req;
  logic we;
  logic [11:0] addr;
  logic [7:0] wdata;
  // Answer from the port end.
  logic [7:0] rdata;
  logic ack;
  logic err;

  // Port end of the bus.
  modport dev (input req, input we, input addr, input wdata, output rdata, output ack, output err);
  // Controller end of the bus.
  modport cpu (output req, output we, output addr, output wdata, input rdata, input ack, input err);
endinterface
`default_nettype wire

// file: hw/gio_port_cell.sv
// One parallel port: output latch, direction, segment select and read value.
`default_nettype none
`include "gio_cfg.svh"
module gio_port_cell #(
  parameter int unsigned W = 8,
  parameter bit HAS_SEG = 1'b0,
  parameter logic [7:0] LATCH_RST = `GIO_LATCH_RST
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Write strobes and data from the bus cycle.
  input wire logic wr_data_i,
  input wire logic wr_dir_i,
  input wire logic wr_seg_i,
  input wire logic [7:0] wdata_i,
  // Pins.
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_o,
  // Read values.
  output logic [7:0] rd_o,
  output logic [7:0] pin_raw_o,
  output logic [7:0] dir_o,
  output logic [7:0] seg_o
);

  // Bits of the slot that exist on this port.
  localparam logic [7:0] MASK = 8'((16'h0001 << W) - 16'h0001);

  // Port widths outside one slot cannot be served.
  if (W < 1 || W > `GIO_SLOT_W) begin : g_bad_w
    $error("port width out of range");
  end

  gio_pkg::gio_cell_state_t s_q;
  gio_pkg::gio_cell_state_t s_d;

  // Next state: each register changes only on its own write strobe.
  always_comb begin
    s_d = s_q;
    if (wr_data_i) begin
      s_d.latch = wdata_i & MASK;
    end
    if (wr_dir_i) begin
      s_d.dir = wdata_i & MASK;
    end
    if (wr_seg_i && HAS_SEG) begin
      s_d.seg = wdata_i & MASK;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_q.latch <= LATCH_RST & MASK;
      s_q.dir <= `GIO_CTRL_RST;
      s_q.seg <= `GIO_CTRL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // The held latch drives the pins while a bit is an output and not a segment.
  assign pin_o = s_q.latch;
  assign pin_oe_o = s_q.dir & ~s_q.seg & MASK;
  // Pin levels pass straight through, with no storage.
  assign pin_raw_o = pin_i & MASK;
  // Output bits read the latch, segment inputs read zero, inputs read the pin.
  assign rd_o = (s_q.dir & s_q.latch) | (~s_q.dir & ~s_q.seg & pin_i & MASK);
  assign dir_o = s_q.dir;
  assign seg_o = s_q.seg;

endmodule // gio_port_cell
`default_nettype wire

// file: hw/gio_port_dev.sv
// Port end: eight parallel ports reached over the instruction bus.
`default_nettype none
`include "gio_cfg.svh"
// Contract
// - Eight ports: 8,3,5,3,8,8,8,8 bits wide.
// - Output latch holds and drives written value.
// - Input paths have no latch; live pin.
// - Outside holds input until read.
// - Pins sampled in first state of read.
// - Output updates in second state of write.
// - Software filters bounce; sampling instant hidden.
// - No read-modify-write on write-only registers.
// - No reserved addresses or unavailable directions.
// - Input bit reads pin, output bit latch; here input bits with segment select set read zero.
module gio_port_dev #(
  parameter int unsigned P_W [`GIO_NPORT] = '{8, 3, 5, 3, 8, 8, 8, 8}
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Instruction bus.
  gio_bus_if.dev bus,
  // Pins, one eight-bit slot per port; unused bits of a slot read zero.
  input wire logic [`GIO_NPORT*`GIO_SLOT_W-1:0] pin_i,
  output logic [`GIO_NPORT*`GIO_SLOT_W-1:0] pin_o,
  output logic [`GIO_NPORT*`GIO_SLOT_W-1:0] pin_oe_o,
  // Segment select per pin, for the display driver that shares the pins.
  output logic [`GIO_NPORT*`GIO_SLOT_W-1:0] seg_sel_o
);

  // Slot map of the pin vectors: slot 0 is the first eight-bit port, slots 1 and 3
  // the three-bit ports, slot 2 the five-bit port and slots 4 to 7 the other
  // eight-bit ports. Bits above a port's width read zero and never drive.

  // Cycle state and the registered answer.
  gio_pkg::gio_dev_state_t s_q;
  gio_pkg::gio_dev_state_t s_d;

  // Per-port read values gathered from the cells.
  logic [7:0] rd_val [`GIO_NPORT];
  // Per-port live pin levels.
  logic [7:0] pin_raw [`GIO_NPORT];
  // Per-port direction readback.
  logic [7:0] dir_rb [`GIO_NPORT];
  // Per-port segment-select readback.
  logic [7:0] seg_rb [`GIO_NPORT];
  // Segment-select address of each port, unused where a port has none.
  logic [11:0] seg_addr [`GIO_NPORT];
  // Write strobe, high only in the second state of a legal write.
  // It is the only way into the registers of the cells.
  logic wr_now;
  // The request names a register in the direction it asks for.
  // It is combinational from the request fields that the requester holds.
  logic acc_ok;

  // Legal access check; anything else is refused without effect.
  // The controller runs the same check and refuses such requests first.
  assign acc_ok = gio_pkg::gio_acc_ok(bus.addr, bus.we);

  // Writes land in the second state of the cycle.
  // The strobe is gated by the access check, so a refused write changes nothing;
  // the cells take the value at the edge that ends the second state.
  assign wr_now = (s_q.st == gio_pkg::GIO_S2) && bus.we && acc_ok;

  // Every port must fit one eight-bit slot; a wider or empty port would break
  // the slot map that software relies on.
  for (genvar j = 0; j < `GIO_NPORT; j++) begin : g_chk_w
    if (P_W[j] < 1 || P_W[j] > `GIO_SLOT_W) begin : g_bad_w
      $error("port width out of range");
    end
  end

  // One cell per port, each with its own width and options.
  // The loop index is also the slot number on the pin vectors.
  for (genvar i = 0; i < `GIO_NPORT; i++) begin : g_port
    // Segment registers exist only on four of the ports.
    localparam bit HAS_SEG = 1'((`GIO_SEG_PORTS >> i) & 8'h01);
    // The three-bit port in slot 1 resets its latch high.
    // All other latches start low, so no pin is driven high out of reset.
    localparam logic [7:0] L_RST = (i == `GIO_P2_SLOT) ? `GIO_P2_LATCH_RST : `GIO_LATCH_RST;
    // Strobes for this port's registers.
    logic wr_data;
    logic wr_dir;
    logic wr_seg;

    // Segment-select address of this port.
    // Ports without a register reuse the last address; the segment gate on the
    // strobe and on the read keeps them from answering to it.
    assign seg_addr[i] = (i == 0) ? `GIO_P1_SEG :
                         (i == 4) ? `GIO_P5_SEG :
                         (i == 6) ? `GIO_P7_SEG : `GIO_P8_SEG;

    // Decode the write strobes for this port.
    // Every address is distinct, so at most one strobe of one port is high.
    assign wr_data = wr_now && (bus.addr == `GIO_DATA_FIRST + 12'(i));
    assign wr_dir = wr_now && (bus.addr == `GIO_DIR_FIRST + 12'(i));
    assign wr_seg = wr_now && HAS_SEG && (bus.addr == seg_addr[i]);

    // Port cell with the width of this port.
    // Each cell masks its own bits, so the bus never sees unused slot bits.
    gio_port_cell #(
      .W(P_W[i]),
      .HAS_SEG(HAS_SEG),
      .LATCH_RST(L_RST)
    ) u_cell (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .wr_data_i(wr_data),
      .wr_dir_i(wr_dir),
      .wr_seg_i(wr_seg),
      .wdata_i(bus.wdata),
      .pin_i(pin_i[i*`GIO_SLOT_W +: `GIO_SLOT_W]),
      .pin_o(pin_o[i*`GIO_SLOT_W +: `GIO_SLOT_W]),
      .pin_oe_o(pin_oe_o[i*`GIO_SLOT_W +: `GIO_SLOT_W]),
      .rd_o(rd_val[i]),
      .pin_raw_o(pin_raw[i]),
      .dir_o(dir_rb[i]),
      .seg_o(seg_rb[i])
    );

    // The display driver sees each segment bit of the port.
    assign seg_sel_o[i*`GIO_SLOT_W +: `GIO_SLOT_W] = seg_rb[i];
  end

  // Next state: walk the cycle from idle through the two states.
  // A request is taken at the edge that sees it in idle; the cycle then spends one
  // clock in the first state, where the answer is captured, and one in the second,
  // where writes land and the acknowledge is shown. The requester drops its
  // request at the acknowledge edge, so idle never takes the same request twice.
  always_comb begin
    s_d = s_q;
    case (s_q.st)
      // Wait for the controller to raise a request.
      // The request fields are held by the requester, so they need no copy here.
      gio_pkg::GIO_IDLE: begin
        if (bus.req) begin
          s_d.st = gio_pkg::GIO_S1;
        end
      end
      // First state: sample the pins or registers into the answer.
      // Pins are taken at the edge that ends this state; a level that changes
      // later in the cycle is not seen until the next read.
      gio_pkg::GIO_S1: begin
        s_d.st = gio_pkg::GIO_S2;
        s_d.err = !acc_ok;
        s_d.rdata = `GIO_CTRL_RST;
        if (!bus.we && acc_ok) begin
          for (int i = 0; i < `GIO_NPORT; i++) begin
            // Port data reads follow the direction of each bit.
            // Output bits give the latch, segment inputs zero, plain inputs the pin.
            if (bus.addr == `GIO_DATA_FIRST + 12'(i)) begin
              s_d.rdata = rd_val[i];
            end
            // Direction registers read back as written.
            if (bus.addr == `GIO_DIR_FIRST + 12'(i)) begin
              s_d.rdata = dir_rb[i];
            end
            // Segment registers read back where the port has one.
            if (((`GIO_SEG_PORTS >> i) & 8'h01) != 8'h00 && bus.addr == seg_addr[i]) begin
              s_d.rdata = seg_rb[i];
            end
          end
          // Pin-read registers always give the live pin levels.
          // They ignore direction and segment bits, so software sees the pin even
          // while the port drives it; writes to them are refused as an error.
          if (bus.addr == `GIO_P2_PIN_READ) begin
            s_d.rdata = pin_raw[`GIO_P2_SLOT];
          end
          if (bus.addr == `GIO_P3_PIN_READ) begin
            s_d.rdata = pin_raw[`GIO_P3_SLOT];
          end
        end
      end
      // Second state: writes take effect and the cycle is acknowledged.
      // Nothing is captured here; the answer was fixed in the first state.
      gio_pkg::GIO_S2: begin
        s_d.st = gio_pkg::GIO_IDLE;
      end
      // Recover from any illegal code.
      // Such a code can only come from a disturbed flop; the next edge is idle.
      default: begin
        s_d.st = gio_pkg::GIO_IDLE;
      end
    endcase
  end

  // State register with synchronous reset.
  // Reset leaves the bus idle with a zero answer and no error, so the first
  // request after release sees a clean cycle.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_q.st <= gio_pkg::GIO_IDLE;
      s_q.rdata <= `GIO_CTRL_RST;
      s_q.err <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // The answer is acknowledged in the second state; data come from flops.
  // The acknowledge is one clock wide; data and error stand until the next
  // second state.
  assign bus.ack = (s_q.st == gio_pkg::GIO_S2);
  assign bus.rdata = s_q.rdata;
  assign bus.err = s_q.err;

endmodule // gio_port_dev
`default_nettype wire

// file: hw/gio_port_host.sv
// Controller end: APB registers that issue single port bus cycles.
`default_nettype none
`include "gio_cfg.svh"
module gio_port_host (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Instruction bus.
  gio_bus_if.cpu bus
);

  gio_pkg::gio_host_state_t s_q;
  gio_pkg::gio_host_state_t s_d;

  // Fields of a command word.
  logic [11:0] cmd_addr;
  logic cmd_we;
  logic [7:0] cmd_wdata;
  // Setup cycle and completed access of an APB transfer.
  logic setup;
  logic access;

  assign cmd_addr = pwdata_i[11:0];
  assign cmd_we = pwdata_i[`GIO_CMD_WE_BIT];
  assign cmd_wdata = pwdata_i[`GIO_CMD_WDATA_LSB +: 8];
  assign setup = psel_i && !penable_i;
  assign access = psel_i && penable_i;

  // Next state: APB decode at setup, command launch at access, bus wait.
  always_comb begin
    s_d = s_q;
    // Answer and error are prepared in the setup cycle.
    if (setup) begin
      s_d.prdata = 32'h0000_0000;
      s_d.pslverr = 1'b0;
      if (paddr_i == `GIO_APB_STAT && !pwrite_i) begin
        s_d.prdata[`GIO_STAT_BUSY_BIT] = (s_q.st == gio_pkg::GIO_H_BUSY);
        s_d.prdata[`GIO_STAT_ERR_BIT] = s_q.err;
        s_d.prdata[`GIO_STAT_RDATA_LSB +: 8] = s_q.rdata;
      end else if (paddr_i == `GIO_APB_CMD && pwrite_i) begin
        // A command while busy, or to a missing register or direction, is refused.
        s_d.pslverr = (s_q.st == gio_pkg::GIO_H_BUSY) || !gio_pkg::gio_acc_ok(cmd_addr, cmd_we);
      end else begin
        s_d.pslverr = 1'b1;
      end
    end
    case (s_q.st)
      // Launch a single read or write; no combined read-modify-write exists.
      gio_pkg::GIO_H_IDLE: begin
        if (access && pwrite_i && paddr_i == `GIO_APB_CMD && !s_q.pslverr) begin
          s_d.st = gio_pkg::GIO_H_BUSY;
          s_d.addr = cmd_addr;
          s_d.we = cmd_we;
          s_d.wdata = cmd_wdata;
        end
      end
      // Hold the request until the port end acknowledges it.
      gio_pkg::GIO_H_BUSY: begin
        if (bus.ack) begin
          s_d.st = gio_pkg::GIO_H_IDLE;
          s_d.err = bus.err;
          // One sample per command; software repeats reads to filter bounce.
          if (!s_q.we) begin
            s_d.rdata = bus.rdata;
          end
        end
      end
      // Recover from any illegal code.
      default: begin
        s_d.st = gio_pkg::GIO_H_IDLE;
      end
    endcase
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_q.st <= gio_pkg::GIO_H_IDLE;
      s_q.addr <= 12'h000;
      s_q.we <= 1'b0;
      s_q.wdata <= 8'h00;
      s_q.rdata <= 8'h00;
      s_q.err <= 1'b0;
      s_q.prdata <= 32'h0000_0000;
      s_q.pslverr <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // APB answers with no wait states.
  assign pready_o = 1'b1;
  assign prdata_o = s_q.prdata;
  assign pslverr_o = s_q.pslverr && access;
  // Bus request fields come from registers.
  assign bus.req = (s_q.st == gio_pkg::GIO_H_BUSY);
  assign bus.we = s_q.we;
  assign bus.addr = s_q.addr;
  assign bus.wdata = s_q.wdata;

endmodule // gio_port_host
`default_nettype wire

// file: verif/gio_bus_asserts.sv
// Checker for the bus between the controller end and the port end.
`default_nettype none
`include "gio_cfg.svh"
module gio_bus_asserts (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Request side.
  input wire logic req,
  input wire logic we,
  input wire logic [11:0] addr,
  input wire logic [7:0] wdata,
  // Answer side.
  input wire logic [7:0] rdata,
  input wire logic ack,
  input wire logic err
);
  // Every check runs on the one clock and sleeps during reset.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // The answer comes in S2, two cycles after the request is raised.
  ack_latency_a: assert property ($rose(req) |=> !ack ##1 ack) else $error("ack latency wrong");
  ack_pulse_a: assert property (ack |=> !ack) else $error("ack longer than one cycle");
  ack_cause_a: assert property (ack |-> req) else $error("ack without request");
  // The requester holds its request steady until answered, then drops it.
  req_hold_a: assert property (req && !ack |=> req && $stable({we, addr, wdata})) else $error("request moved");
  req_drop_a: assert property (ack |=> !req) else $error("request not dropped");
  // Read data stays put while no cycle runs.
  answer_hold_a: assert property (!req |=> $stable(rdata) && $stable(err)) else $error("answer changed");
  // Refused requests never reach the port end: no pin-read write is acknowledged and no answer carries an error.
  pin_wr_err_a: assert property (ack && (addr == `GIO_P2_PIN_READ || addr == `GIO_P3_PIN_READ) |-> !we)
    else $error("pin-read write reached port end");
  reserved_err_a: assert property (ack |-> !err)
    else $error("refused request reached port end");
  data_ok_a: assert property (ack && addr >= `GIO_DATA_FIRST && addr <= `GIO_DATA_LAST |-> !err)
    else $error("data latch access refused");
  // Main traffic kinds.
  wr_c: cover property (ack && we);
  rd_c: cover property (ack && !we);
  pin_rd_c: cover property (ack && !we && addr == `GIO_P3_PIN_READ);
endmodule // gio_bus_asserts
`default_nettype wire

// file: verif/io_port_access_timing_tb.sv
// Testbench driving both ends of the port block over APB and pins.
`default_nettype none
`include "gio_cfg.svh"
module io_port_access_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, reset and counters.
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  // APB master.
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Pins.
  logic [63:0] pin_i = 64'h0000_0000_0000_0000;
  logic [63:0] pin_o;
  logic [63:0] pin_oe;
  logic [63:0] seg_sel;
  // Expected port contents and widths.
  logic [7:0] lat [8];
  logic [7:0] dir [8];
  logic [7:0] seg [8];
  int pw [8] = '{8, 3, 5, 3, 8, 8, 8, 8};
  logic [7:0] r;
  logic [31:0] s32;
  logic e;
  int sl;
  int k;
  logic [7:0] d;

  gio_bus_if bus_if ();
  gio_port_host gio_port_host_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .bus(bus_if));
  gio_port_dev gio_port_dev_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus(bus_if), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe_o(pin_oe), .seg_sel_o(seg_sel));
  gio_bus_asserts gio_bus_asserts_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .req(bus_if.req), .we(bus_if.we),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .ack(bus_if.ack), .err(bus_if.err));

  // Clock at 125 MHz.
  initial forever #4 clk_i = ~clk_i;
  // Cuts a hang short.
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end

  // Bits that a port really has.
  function automatic logic [7:0] mk(int n);
    return 8'hff >> (8 - pw[n]);
  endfunction
  // Read value: output bits give the latch, plain inputs the live pin.
  function automatic logic [7:0] exp_rd(int n);
    return mk(n) & ((dir[n] & lat[n]) | (~dir[n] & ~seg[n] & pin_i[8*n+:8]));
  endfunction
  // Segment register of a slot, or zero when it has none.
  function automatic logic [11:0] seg_a(int n);
    case (n)
      0: return `GIO_P1_SEG;
      4: return `GIO_P5_SEG;
      6: return `GIO_P7_SEG;
      7: return `GIO_P8_SEG;
      default: return 12'h000;
    endcase
  endfunction

  // Counts one comparison and reports a mismatch.
  task automatic chk(input logic [63:0] g, input logic [63:0] x);
    cmp_count++;
    if (g !== x) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // One APB transfer; data and error are taken at the pready edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic pe);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    pe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Polls status until the port cycle is over.
  task automatic wait_idle(output logic [7:0] rd, output logic er);
    logic [31:0] st;
    logic pe;
    int n;
    st = 32'h0000_0001;
    n = 0;
    while (st[0] !== 1'b0 && n < 20) begin
      apb(1'b0, `GIO_APB_STAT, 32'h0000_0000, st, pe);
      n++;
    end
    chk(st[0], 1'b0);
    rd = st[15:8];
    er = st[1];
  endtask
  // One port cycle; with tm set, slot 2 pins change entering S1 and after S2.
  task automatic op(input logic w, input logic [11:0] a, input logic [7:0] wd, input logic tm,
                    input logic [7:0] pb, input logic [7:0] pc, output logic [7:0] rd, output logic er);
    logic [63:0] b;
    logic [31:0] x;
    logic pe;
    int n;
    b = pin_o;
    apb(1'b1, `GIO_APB_CMD, {11'h000, w, wd, a}, x, pe);
    chk(pe, 1'b0);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
      if (tm && n == 1) begin
        @(posedge clk_i);
        pin_i[23:16] <= pb;
      end
    end while (bus_if.ack !== 1'b1 && n < 20);
    chk(n, 3);
    chk(pin_o, b);
    if (tm) begin
      @(posedge clk_i);
      pin_i[23:16] <= pc;
    end
    wait_idle(rd, er);
  endtask

  // Closing report and verdict.
  task automatic end_of_test();
    $display("compares=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    s32 = $urandom(96);
    for (int i = 0; i < 8; i++) begin
      lat[i] = 8'h00;
      dir[i] = 8'h00;
      seg[i] = 8'h00;
    end
    lat[1] = 8'h07;
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(negedge clk_i);
    chk(pin_o, 64'h0000_0000_0000_0700);
    chk(pin_oe | seg_sel, 64'h0000_0000_0000_0000);
    // Random traffic; pins are held steady through each cycle.
    for (int i = 0; i < 80; i++) begin
      sl = (i < 8) ? i : int'($urandom % 8);
      k = $urandom % 7;
      d = (i < 8) ? 8'hff : 8'($urandom);
      @(posedge clk_i);
      pin_i <= {$urandom, $urandom};
      if (k == 2 && seg_a(sl) == 12'h000) k = 3;
      if (k == 4 && sl != 1 && sl != 2) k = 3;
      if (k == 6 && seg_a(sl) == 12'h000) k = 5;
      case (k)
        0: begin
          op(1'b1, 12'(`GIO_DATA_FIRST + sl), d, 1'b0, 8'h00, 8'h00, r, e);
          lat[sl] = d;
        end
        1: begin
          op(1'b1, 12'(`GIO_DIR_FIRST + sl), d, 1'b0, 8'h00, 8'h00, r, e);
          dir[sl] = d;
        end
        2: begin
          op(1'b1, seg_a(sl), d, 1'b0, 8'h00, 8'h00, r, e);
          seg[sl] = d;
        end
        3: begin
          op(1'b0, 12'(`GIO_DATA_FIRST + sl), 8'h00, 1'b0, 8'h00, 8'h00, r, e);
          chk(r, exp_rd(sl));
        end
        5: begin
          op(1'b0, 12'(`GIO_DIR_FIRST + sl), 8'h00, 1'b0, 8'h00, 8'h00, r, e);
          chk(r, dir[sl] & mk(sl));
        end
        6: begin
          op(1'b0, seg_a(sl), 8'h00, 1'b0, 8'h00, 8'h00, r, e);
          chk(r, seg[sl] & mk(sl));
        end
        default: begin
          op(1'b0, (sl == 1) ? `GIO_P2_PIN_READ : `GIO_P3_PIN_READ, 8'h00, 1'b0, 8'h00, 8'h00, r, e);
          chk(r, pin_i[8*sl+:8] & mk(sl));
        end
      endcase
      chk(e, 1'b0);
      for (int j = 0; j < 8; j++) begin
        chk(pin_o[8*j+:8], lat[j] & mk(j));
        chk(pin_oe[8*j+:8], dir[j] & ~seg[j] & mk(j));
        chk(seg_sel[8*j+:8], seg[j]);
      end
    end
    // Pins are taken in S1: a change entering S1 is seen, one after S2 is not.
    op(1'b0, `GIO_P3_PIN_READ, 8'h00, 1'b1, 8'h15, 8'h0a, r, e);
    chk(r, 8'h15);
    // Refused requests: pin-read write, reserved places, status write.
    apb(1'b1, `GIO_APB_CMD, {11'h000, 1'b1, 8'hff, `GIO_P2_PIN_READ}, s32, e);
    chk(e, 1'b1);
    apb(1'b1, `GIO_APB_CMD, {11'h000, 1'b0, 8'h00, 12'hfa2}, s32, e);
    chk(e, 1'b1);
    apb(1'b0, 12'h008, 32'h0000_0000, s32, e);
    chk({e, s32}, {1'b1, 32'h0000_0000});
    apb(1'b1, `GIO_APB_STAT, 32'h0000_0000, s32, e);
    chk(e, 1'b1);
    // A second command while busy is refused and the first completes.
    apb(1'b1, `GIO_APB_CMD, {11'h000, 1'b1, 8'h05, `GIO_DATA_FIRST}, s32, e);
    apb(1'b1, `GIO_APB_CMD, {11'h000, 1'b1, 8'h0a, `GIO_DATA_FIRST}, s32, e);
    chk(e, 1'b1);
    wait_idle(r, e);
    chk(pin_o[7:0], 8'h05);
    end_of_test();
  end
endmodule // io_port_access_timing_tb
`default_nettype wire
